// file: logic/rwd_top.sv
// Purpose: Runaway supervisor watching the on-package processor.
// Assumes: One core clock; refresh arrives on a pin from the processor.
// Notes:   The count source is an enable pulse divided from the core clock.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/100ps
module rwd_top #(
  parameter int unsigned TICK_DIV  = rwd_pkg::TICK_DIV_DEF,
  parameter int unsigned RST_PULSE = rwd_pkg::RST_PULSE_DEF
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        REFRESH_PULSE_INPUT_I,
  output logic             CHARGE_FET_ENABLE_O,
  output logic             DISCHARGE_FET_ENABLE_O,
  output logic             RESET_OUTPUT_PIN_N_O,
  output logic             IRQ_O
);
  generate
    if (TICK_DIV < 1 || TICK_DIV > 65535 || RST_PULSE < 8 || RST_PULSE > 255)
    begin : g_bad_param
      $error("rwd_top: parameter out of range");
    end
  endgenerate

  rwd_pkg::rwd_apb_req_t req;
  assign req = '{sel: PSEL_I, en: PENABLE_I, wr: PWRITE_I, addr: PADDR_I, wdata: PWDATA_I};

  // Bus decode.
  wire setup_ph  = req.sel && !req.en;
  wire access_ph = req.sel && req.en;
  wire wr_acc    = access_ph && req.wr;
  wire rd_acc    = access_ph && !req.wr;
  wire hit_ctrl  = req.addr == rwd_pkg::OFS_CTRL;
  wire hit_fet   = req.addr == rwd_pkg::OFS_FET;
  wire hit_stat  = req.addr == rwd_pkg::OFS_STATUS;
  wire hit_mask  = req.addr == rwd_pkg::OFS_MASK;
  wire hit_cnt   = req.addr == rwd_pkg::OFS_COUNT;
  wire wr_ctrl   = wr_acc && hit_ctrl;
  wire wr_fet    = wr_acc && hit_fet;
  wire wr_mask   = wr_acc && hit_mask;
  wire rd_stat   = rd_acc && hit_stat;

  rwd_pkg::rwd_ctrl_t   ctrl_q;
  rwd_pkg::rwd_ctrl_t   ctrl_d;
  rwd_pkg::rwd_stage_t  stage_q;
  rwd_pkg::rwd_stage_t  stage_d;
  logic [1:0]                    fet_q;
  logic [1:0]                    fet_d;
  logic [rwd_pkg::ST_W-1:0]      status_q;
  logic [rwd_pkg::ST_W-1:0]      status_d;
  logic [rwd_pkg::ST_W-1:0]      mask_q;
  logic [rwd_pkg::PRESC_W-1:0]   presc_q;
  logic [rwd_pkg::CNT_W-1:0]     cnt_q;
  logic [15:0]                   div_q;
  logic [7:0]                    rst_cnt_q;
  logic [2:0]                    refresh_sync_q;
  logic [31:0]                   prdata_q;
  logic                          irq_q;

  // The pin is not sampled before two flops; the pull-down sits in the pad.
  wire refresh_pin  = refresh_sync_q[1] && !refresh_sync_q[2];
  wire refresh_sw   = wr_ctrl && req.wdata[rwd_pkg::CTRL_REFRESH];
  assign ctrl_d     = '{period_sel: req.wdata[rwd_pkg::CTRL_SEL_HI:rwd_pkg::CTRL_SEL_LO],
                        runaway_reset_select: req.wdata[rwd_pkg::CTRL_RSEL]};
  wire period_chg   = wr_ctrl && (ctrl_d.period_sel != ctrl_q.period_sel);
  wire restart      = refresh_pin || refresh_sw || period_chg;

  // Count source: one enable pulse per divided oscillator period.
  wire tick = div_q == 16'(TICK_DIV - 1);
  wire [rwd_pkg::CHAIN_W-1:0] chain = {cnt_q, presc_q};
  wire [rwd_pkg::CHAIN_W-1:0] limit =
    (ctrl_q.period_sel == rwd_pkg::SEL_2S) ? rwd_pkg::LIMIT_2S :
    (ctrl_q.period_sel == rwd_pkg::SEL_4S) ? rwd_pkg::LIMIT_4S :
    rwd_pkg::LIMIT_8S;
  wire ovf        = tick && !restart && (chain == limit);
  wire ovf_first  = ovf && (stage_q == rwd_pkg::STAGE_FIRST);
  wire ovf_second = ovf && (stage_q == rwd_pkg::STAGE_SECOND);
  wire [rwd_pkg::CHAIN_W-1:0] chain_next =
    (restart || ovf) ? '0 : (tick ? chain + 1'b1 : chain);

  // Second overflow returns to the first stage so the flag can fire again.
  assign stage_d = restart    ? rwd_pkg::STAGE_FIRST :
                   ovf_first  ? rwd_pkg::STAGE_SECOND :
                   ovf_second ? rwd_pkg::STAGE_FIRST : stage_q;

  // The hardware clear beats a software write in the same cycle.
  assign fet_d = ovf_second ? 2'h0 :
                 (wr_fet ? req.wdata[rwd_pkg::FET_DSG:rwd_pkg::FET_CHG] : fet_q);

  // A new event wins over the read that clears the status.
  wire [rwd_pkg::ST_W-1:0] events = {ovf_second, ovf_first};
  assign status_d = (rd_stat ? '0 : status_q) | events;

  wire reset_req = ovf_second && ctrl_q.runaway_reset_select;

  wire [31:0] rd_mux =
    hit_ctrl ? {28'h0, 1'b0, ctrl_q.runaway_reset_select, ctrl_q.period_sel} :
    hit_fet  ? {30'h0, fet_q} :
    hit_stat ? {30'h0, status_q} :
    hit_mask ? {30'h0, mask_q} :
    hit_cnt  ? {13'h0, chain} : 32'h0;

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      div_q          <= '0;
      presc_q        <= '0;
      cnt_q          <= '0;
      stage_q        <= rwd_pkg::STAGE_FIRST;
      refresh_sync_q <= '0;
    end
    else
    begin
      div_q          <= tick ? '0 : div_q + 1'b1;
      presc_q        <= chain_next[rwd_pkg::PRESC_W-1:0];
      cnt_q          <= chain_next[rwd_pkg::CHAIN_W-1:rwd_pkg::PRESC_W];
      stage_q        <= stage_d;
      refresh_sync_q <= {refresh_sync_q[1:0], REFRESH_PULSE_INPUT_I};
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ctrl_q   <= '{period_sel: rwd_pkg::CTRL_RST, runaway_reset_select: 1'b0};
      fet_q    <= rwd_pkg::FET_RST;
      status_q <= '0;
      mask_q   <= '0;
      prdata_q <= '0;
      irq_q    <= 1'b0;
    end
    else
    begin
      ctrl_q   <= wr_ctrl ? ctrl_d : ctrl_q;
      fet_q    <= fet_d;
      status_q <= status_d;
      mask_q   <= wr_mask ? req.wdata[rwd_pkg::ST_W-1:0] : mask_q;
      prdata_q <= setup_ph ? rd_mux : prdata_q;
      irq_q    <= |(status_d & mask_q);
    end
  end

  // Power-on reset holds the pin low; a runaway request stretches a pulse.
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      rst_cnt_q <= 8'(RST_PULSE);
    else if (reset_req)
      rst_cnt_q <= 8'(RST_PULSE);
    else if (rst_cnt_q != 8'h00)
      rst_cnt_q <= rst_cnt_q - 8'h01;
  end

  assign RESET_OUTPUT_PIN_N_O   = (rst_cnt_q == 8'h00) && !SYS_RST_I;
  assign PRDATA_O               = prdata_q;
  assign PREADY_O               = 1'b1;
  assign PSLVERR_O              = 1'b0;
  assign CHARGE_FET_ENABLE_O    = fet_q[rwd_pkg::FET_CHG];
  assign DISCHARGE_FET_ENABLE_O = fet_q[rwd_pkg::FET_DSG];
  assign IRQ_O                  = irq_q;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_refresh_restart: assert property (refresh_pin |=> chain == '0)
    else $error("chain not cleared by refresh");
  a_period_restart: assert property (period_chg |=> chain == '0 && stage_q == rwd_pkg::STAGE_FIRST)
    else $error("period change did not restart");
  a_first_flag: assert property (ovf_first |=> status_q[rwd_pkg::ST_FLAG] && stage_q == rwd_pkg::STAGE_SECOND)
    else $error("first overflow did not raise flag");
  a_second_fets: assert property (ovf_second |=> !CHARGE_FET_ENABLE_O && !DISCHARGE_FET_ENABLE_O)
    else $error("FET drives not cleared");
  a_runaway_reset: assert property (reset_req |=> !RESET_OUTPUT_PIN_N_O [*8])
    else $error("runaway reset pulse too short");
  a_no_reset_sel0: assert property (ovf_second && !ctrl_q.runaway_reset_select && RESET_OUTPUT_PIN_N_O
    |=> RESET_OUTPUT_PIN_N_O)
    else $error("reset raised with select clear");
  a_flag_sticky: assert property (status_q[rwd_pkg::ST_FLAG] && !rd_stat |=> status_q[rwd_pkg::ST_FLAG])
    else $error("flag lost without read");
  a_limit_2s: assert property (tick && !restart && ctrl_q.period_sel == rwd_pkg::SEL_2S
    && chain == rwd_pkg::LIMIT_2S |=> chain == '0)
    else $error("2 s period did not wrap");
  a_tick_gap: assert property (tick && TICK_DIV > 1 |=> !tick)
    else $error("count source ticks too close");
  a_chain_hold: assert property (!tick && !restart && !ovf |=> $stable(chain))
    else $error("chain moved without tick");

  // Counts how long the reset pin has been low since power-on reset let go.
  // A long stretch would mean the pulse counter was reloaded or stuck.
  logic [7:0] pin_low_q;

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      pin_low_q <= 8'h00;
    else if (RESET_OUTPUT_PIN_N_O)
      pin_low_q <= 8'h00;
    else if (pin_low_q != 8'hff)
      pin_low_q <= pin_low_q + 8'h01;
  end

  // Count source and chain.
  a_div_wrap: assert property (tick |=> div_q == '0)
    else $error("divider did not wrap on tick");
  a_div_step: assert property (!tick |=> div_q == $past(div_q) + 1'b1)
    else $error("divider did not advance");
  a_chain_step: assert property (tick && !restart && chain != limit
    |=> chain == $past(chain) + 1'b1)
    else $error("chain did not advance on tick");
  a_chain_bound: assert property (chain <= limit)
    else $error("chain beyond selected limit");
  a_limit_4s: assert property (tick && !restart && ctrl_q.period_sel == rwd_pkg::SEL_4S
    && chain == rwd_pkg::LIMIT_4S |=> chain == '0)
    else $error("4 s period did not wrap");
  a_limit_8s: assert property (tick && !restart && ctrl_q.period_sel[1]
    && chain == rwd_pkg::LIMIT_8S |=> chain == '0)
    else $error("8 s period did not wrap");
  a_ctrl_write: assert property (wr_ctrl |=> ctrl_q == $past(ctrl_d))
    else $error("control write not taken");

  // Restart sources.
  a_refresh_once: assert property (refresh_pin |=> !refresh_pin)
    else $error("held refresh counted twice");
  a_sw_refresh: assert property (refresh_sw |=> chain == '0)
    else $error("software refresh did not restart");
  a_restart_stage: assert property (restart |=> stage_q == rwd_pkg::STAGE_FIRST)
    else $error("restart left second stage");

  // Overflow stages, status and interrupt.
  a_stage_return: assert property (ovf_second |=> stage_q == rwd_pkg::STAGE_FIRST)
    else $error("second overflow kept second stage");
  a_status_second: assert property (ovf_second |=> status_q[rwd_pkg::ST_SECOND])
    else $error("second overflow not recorded");
  a_read_clear: assert property (rd_stat && events == '0 |=> status_q == '0)
    else $error("status not cleared by read");
  a_flag_clear: assert property (rd_stat && !ovf_first
    |=> !status_q[rwd_pkg::ST_FLAG])
    else $error("flag survived its read");
  a_first_irq: assert property (ovf_first && mask_q[rwd_pkg::ST_FLAG] && !wr_mask
    |=> IRQ_O)
    else $error("unmasked flag raised no interrupt");
  a_irq_source: assert property (IRQ_O |-> status_q != '0)
    else $error("interrupt without status");
  a_irq_masked: assert property (mask_q == '0 && !wr_mask |=> !IRQ_O)
    else $error("masked status raised interrupt");
  a_mask_write: assert property (wr_mask
    |=> mask_q == $past(req.wdata[rwd_pkg::ST_W-1:0]))
    else $error("mask write not taken");

  // Drives and reset pin.
  a_fet_hold: assert property (!ovf_second && !wr_fet |=> $stable(fet_q))
    else $error("FET enables moved by themselves");
  a_first_no_reset: assert property (ovf_first && RESET_OUTPUT_PIN_N_O
    |=> RESET_OUTPUT_PIN_N_O)
    else $error("first overflow pulled reset");
  a_pulse_load: assert property (reset_req |=> rst_cnt_q == 8'(RST_PULSE))
    else $error("reset pulse counter not loaded");
  a_pulse_bound: assert property (pin_low_q <= 8'(RST_PULSE))
    else $error("reset pin held low too long");

  c_first_ovf:  cover property (ovf_first);
  c_second_rst: cover property (reset_req);
  c_refresh:    cover property (refresh_pin ##1 chain == '0);
  c_period_chg: cover property (period_chg);
  c_stat_clear: cover property (rd_stat && status_q != '0);
endmodule : rwd_top

// file: logic/rwd_pkg.sv
// Purpose: Shared constants and types of the runaway supervisor.
// Assumes: APB register access with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package rwd_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned CHAIN_W       = 19;
  localparam int unsigned PRESC_W       = 3;
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned OVF_2S_S      = 2;
  localparam int unsigned OVF_4S_S      = 4;
  localparam int unsigned OVF_8S_S      = 8;
  localparam int unsigned SRC_DIV       = 4;
  // Count-source rate chosen so the full chain spans the longest period.
  localparam int unsigned TICK_HZ       = (1 << CHAIN_W) / OVF_8S_S;
  localparam int unsigned TICK_DIV_DEF  = CLK_HZ / TICK_HZ;
  localparam logic [CHAIN_W-1:0] LIMIT_2S = CHAIN_W'((1 << CHAIN_W) / OVF_8S_S * OVF_2S_S - 1);
  localparam logic [CHAIN_W-1:0] LIMIT_4S = CHAIN_W'((1 << CHAIN_W) / OVF_8S_S * OVF_4S_S - 1);
  localparam logic [CHAIN_W-1:0] LIMIT_8S = CHAIN_W'((1 << CHAIN_W) - 1);
  localparam int unsigned RST_PULSE_DEF = 16;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FET    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0c;
  localparam logic [7:0] OFS_COUNT  = 8'h10;

  localparam int unsigned CTRL_SEL_LO  = 0;
  localparam int unsigned CTRL_SEL_HI  = 1;
  localparam int unsigned CTRL_RSEL    = 2;
  localparam int unsigned CTRL_REFRESH = 3;
  localparam int unsigned FET_CHG      = 0;
  localparam int unsigned FET_DSG      = 1;
  localparam int unsigned ST_FLAG      = 0;
  localparam int unsigned ST_SECOND    = 1;
  localparam int unsigned ST_W         = 2;

  localparam logic [1:0] SEL_2S = 2'h0;
  localparam logic [1:0] SEL_4S = 2'h1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] FET_RST  = 2'h0;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } rwd_apb_req_t;

  typedef struct packed {
    logic [1:0] period_sel;
    logic       runaway_reset_select;
  } rwd_ctrl_t;

  typedef enum logic {STAGE_FIRST, STAGE_SECOND} rwd_stage_t;
endpackage : rwd_pkg

// file: tb/rwd_mcu_model.sv
// Purpose: Processor side that pulses the refresh line.
// Assumes: The bench asks for each pulse with a one-cycle kick.
// Notes:   The idle line is driven low, standing in for the pull-down.
`timescale 1ns/100ps
module rwd_mcu_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic kick_i,
  output logic      refresh_o
);
  logic [1:0] hold_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_q <= 2'h0;
    else if (kick_i)
      hold_q <= 2'h2;
    else if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
  end

  // Two cycles high so the pulse cannot slip past the synchroniser.
  assign refresh_o = (hold_q != 2'h0);
endmodule : rwd_mcu_model

// file: tb/runaway_watchdog_afe_tb.sv
// Purpose: Self-checking bench for the runaway supervisor.
// Assumes: TICK_DIV is 1, so one tick per core cycle.
// Notes:   Only the 2 s period runs to overflow, to bound the run.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module runaway_watchdog_afe_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic        kick = 1'b0;
  logic        refr;
  logic        chg;
  logic        dsg;
  logic        rst_n;
  logic        irq;
  logic [31:0] rd;
  int          err_total = 0;
  int          n_compared = 0;
  int          i;

  rwd_top #(.TICK_DIV(1), .RST_PULSE(16)) u_rwd_top (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .REFRESH_PULSE_INPUT_I(refr),
    .CHARGE_FET_ENABLE_O(chg), .DISCHARGE_FET_ENABLE_O(dsg),
    .RESET_OUTPUT_PIN_N_O(rst_n), .IRQ_O(irq));
  rwd_mcu_model u_rwd_mcu_model (.clk_i(clk), .rst_i(rst), .kick_i(kick), .refresh_o(refr));

  always #4 clk = ~clk;

  task automatic clks(input int n);
    repeat (n) @(posedge clk);
  endtask : clks

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen  <= 1'b0;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic t_reset;
    `CHK("rst_pin_hold", 1'b0, rst_n)
    `CHK("refresh_idle", 1'b0, refr)
    clks(20);
    `CHK("rst_pin_idle", 1'b1, rst_n)
    apb(1'b0, rwd_pkg::OFS_FET, 32'h0);
    `CHK("fet_reset", 32'h0, rd)
    `CHK("no_slverr", 1'b0, perr)
  endtask : t_reset

  task automatic t_restart;
    apb(1'b1, rwd_pkg::OFS_FET, 32'h3);
    `CHK("chg_on", 1'b1, chg)
    `CHK("dsg_on", 1'b1, dsg)
    clks(100);
    apb(1'b0, rwd_pkg::OFS_COUNT, 32'h0);
    `CHK("cnt_runs", 1'b1, rd >= 32'd100)
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    clks(4);
    apb(1'b0, rwd_pkg::OFS_COUNT, 32'h0);
    `CHK("cnt_refresh", 1'b1, rd < 32'd16)
    clks(100);
    apb(1'b1, rwd_pkg::OFS_CTRL, 32'h1);
    apb(1'b0, rwd_pkg::OFS_COUNT, 32'h0);
    `CHK("cnt_period", 1'b1, rd < 32'd16)
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, rwd_pkg::OFS_CTRL, 32'(i));
      apb(1'b0, rwd_pkg::OFS_CTRL, 32'h0);
      `CHK("ctrl_period", 2'(i), rd[1:0])
    end
    // Leaving 8 s for 2 s also restarts the chain before the long wait.
    apb(1'b1, rwd_pkg::OFS_CTRL, 32'h4);
  endtask : t_restart

  task automatic t_overflow;
    apb(1'b1, rwd_pkg::OFS_MASK, 32'h3);
    for (i = 0; i < 140000 && irq !== 1'b1; i++) @(negedge clk);
    `CHK("irq_first", 1'b1, irq)
    `CHK("fet_first", 1'b1, chg)
    `CHK("rst_pin_first", 1'b1, rst_n)
    @(posedge clk);
    apb(1'b1, rwd_pkg::OFS_MASK, 32'h0);
    clks(2);
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b0, rwd_pkg::OFS_STATUS, 32'h0);
    `CHK("status_first", 32'h1, rd)
    apb(1'b0, rwd_pkg::OFS_STATUS, 32'h0);
    `CHK("status_clr", 32'h0, rd)
    apb(1'b1, rwd_pkg::OFS_MASK, 32'h3);
    clks(2);
    `CHK("irq_clear", 1'b0, irq)
    for (i = 0; i < 140000 && chg !== 1'b0; i++) @(negedge clk);
    `CHK("chg_off", 1'b0, chg)
    `CHK("dsg_off", 1'b0, dsg)
    @(posedge clk);
    `CHK("rst_pin_run", 1'b0, rst_n)
    apb(1'b0, rwd_pkg::OFS_STATUS, 32'h0);
    `CHK("status_second", 32'h2, rd)
    clks(20);
    `CHK("rst_pin_end", 1'b1, rst_n)
  endtask : t_overflow

  task automatic results;
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  initial
  begin
    clks(20);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_restart();
    t_overflow();
    results();
  end

  // Two 2 s overflows take about 2.1 ms of core time.
  initial
  begin
    #3_000_000;
    err_total++;
    results();
  end
endmodule : runaway_watchdog_afe_tb
